// ### design/cdc_cfg_pkg.sv
// package: register map, field positions, reset values and timing for the front-end config bank
package cdc_cfg_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] OFS_LOWFREQ_CLOCK_TUNE = 3'h0;
  localparam logic [2:0] OFS_OSCILLATOR_CONTROL = 3'h1;
  localparam logic [2:0] OFS_DISCHARGE_RES_SEL = 3'h2;
  localparam logic [2:0] OFS_AUX_PORT_CHARGE = 3'h3;
  localparam logic [2:0] OFS_SENSOR_MODE = 3'h4;
  localparam logic [2:0] OFS_SEQ_STATUS = 3'h5;
  localparam int NUM_REGS = 6;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FINE_TRIM_LSB = 2;
  localparam int COARSE_LSB = 0;
  localparam int OSC_DISABLE_BIT = 7;
  localparam int OSC_QUARTER_BIT = 5;
  localparam int OSC_RUN_LSB = 0;
  localparam int DSEL_HIGH_LSB = 6;
  localparam int DSEL_LOW_LSB = 4;
  localparam int INT_DSCHG_EN_BIT = 3;
  localparam int EXT_DSCHG_EN_BIT = 1;
  localparam int AUX_PD_OFF_BIT = 6;
  localparam int AUX_INTREF_BIT = 5;
  localparam int DSCHG_PERM_BIT = 2;
  localparam int AUX_PERM_BIT = 1;
  localparam int CHG_RES_BIT = 0;
  localparam int REF_INT_BIT = 7;
  localparam int COMP_EXT_BIT = 5;
  localparam int COMP_INT_BIT = 4;
  localparam int DIFF_BIT = 1;
  localparam int FLOAT_BIT = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_LOWFREQ_CLOCK_TUNE = 8'h1C;
  localparam logic [7:0] RST_OSCILLATOR_CONTROL = 8'h00;
  localparam logic [7:0] RST_DISCHARGE_RES_SEL = 8'hA8;
  localparam logic [7:0] RST_AUX_PORT_CHARGE = 8'h10;
  localparam logic [7:0] RST_SENSOR_MODE = 8'h00;

  // ---------------------------------------------------------------
  // fast oscillator run-mode codes
  // ---------------------------------------------------------------
  localparam logic [2:0] RUN_OFF = 3'h0;
  localparam logic [2:0] RUN_PERMANENT = 3'h1;
  localparam logic [2:0] RUN_LAT_31 = 3'h2;
  localparam logic [2:0] RUN_LAT_2 = 3'h3;
  localparam logic [2:0] RUN_LAT_1 = 3'h6;
  localparam logic [4:0] LAT_PERIODS_1 = 5'h01;
  localparam logic [4:0] LAT_PERIODS_2 = 5'h02;
  localparam logic [4:0] LAT_PERIODS_31 = 5'h1F;

  // ---------------------------------------------------------------
  // decoded configuration handed to the sequencer
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] slowClkFineTrim;
    logic [1:0] slowClkCoarseRange;
    logic fastOscDisable;
    logic fastOscQuarter;
    logic [2:0] fastOscRunMode;
    logic [1:0] dischgResSelLowPorts;
    logic [1:0] dischgResSelHighPorts;
    logic internalDischgEnable;
    logic externalDischgEnable;
    logic auxPulldownOff;
    logic auxDuringIntref;
    logic dischgResPermanent;
    logic auxPortPermanent;
    logic chargeResSelect;
    logic refInternal;
    logic offchipParasiticComp;
    logic onchipParasiticComp;
    logic differential;
    logic floating;
  } cdc_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETTLE = 2'b01,
    ST_MEASURE = 2'b11
  } osc_state_t;

endpackage

// ### design/cdc_frontend_config_regs.sv
// config register bank for the capacitance front end, with oscillator latency control
//
// Summary of operation
// R1: register 0x00 bits 5:2 hold slow clock fine trim, 0 to 15, typical 7.
// R2: register 0x00 bits 1:0 pick slow clock range 10/50/100/200 kHz.
// R3: register 0x01 bit 7 set disables the fast oscillator clock; default 0.
// R4: register 0x01 bit 5 divides fast oscillator 2 MHz by four.
// R5: register 0x01 bits 2:0: off, permanent, or 1/2/31 slow-period latency.
// R6: with a latency code, start oscillator and wait settling before each measurement.
// R7: register 0x02 bits 5:4 pick discharge resistor for ports 0-3 and 6.
// R8: register 0x02 bits 7:6 pick discharge resistor for ports 4 and 5.
// R9: register 0x02 bit 3 enables internal discharge resistors; default on.
// R10: register 0x02 bit 1 switches aux pin only during discharge; software disables pull-down.
// R11: register 0x03 bit 6 set disables the aux pin pull-down.
// R12: register 0x03 bit 5 activates aux port only during internal reference conversion.
// R13: register 0x03 bit 2 keeps on-chip discharge resistor always connected.
// R14: register 0x03 bit 1 keeps aux port permanently active; software disables pull-down.
// R15: register 0x03 bit 0 picks charge resistor 10 k or 180 k.
// R16: register 0x04 bit 7 selects internal reference on port 6 or external.
// R17: software must not set off-chip compensation unless sensors are floating.
// R18: register 0x04 bit 4 activates on-chip parasitic and gain compensation.
// R19: register 0x04 bit 1 selects single or differential sensors.
// R20: register 0x04 bit 0 selects grounded or floating sensors.
// R21: registers are 8 bits, hold until rewritten or reset, drive sequencer continuously.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps

module cdc_frontend_config_regs
  import cdc_cfg_pkg::*;
#(
  parameter int ADDR_W = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // sequencer side
  input wire logic slowClkTick,
  input wire logic measRequest,
  input wire logic dischargePhase,
  input wire logic intRefConversion,
  output cdc_cfg_t cfg,
  output logic fastOscEnable,
  output logic measStart,
  output logic auxPinSwitch,
  output logic auxPulldownEnable,
  output logic intDischgConnect
);

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  // the decode indexes three address bits; a narrower port cannot reach every register
  if (ADDR_W < 3) begin : g_addr_w_check
    $error("ADDR_W must be at least 3");
  end

  // ---------------------------------------------------------------
  // register storage and internal state
  // ---------------------------------------------------------------
  logic [7:0] lowfreqClockTune;
  logic [7:0] oscillatorControl;
  logic [7:0] dischargeResistorSelect;
  logic [7:0] auxPortChargeControl;
  logic [7:0] sensorModeControl;
  logic configErr;
  logic [7:0] seqStatus;
  osc_state_t oscState;
  logic [4:0] settleCount;
  logic [4:0] settleTarget;
  logic slowTickMeta;
  logic slowTickSync;
  logic slowTickLast;
  logic slowTickRise;
  logic addrHit;
  // write enables, one per register
  logic wrTune;
  logic wrOsc;
  logic wrRes;
  logic wrAux;
  logic wrMode;
  // next values of the registered outputs
  logic [7:0] next_regRdData;
  logic next_auxPinSwitch;
  logic next_auxPulldownEnable;
  logic next_intDischgConnect;
  logic next_fastOscEnable;
  // settling is abandoned when its mode goes away
  logic settleAbort;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  assign addrHit = (regAddr < ADDR_W'(NUM_REGS));

  // one strobe per register keeps each storage process independent
  assign wrTune = regWrite && addrHit && (regAddr[2:0] == OFS_LOWFREQ_CLOCK_TUNE);
  assign wrOsc = regWrite && addrHit && (regAddr[2:0] == OFS_OSCILLATOR_CONTROL);
  assign wrRes = regWrite && addrHit && (regAddr[2:0] == OFS_DISCHARGE_RES_SEL);
  assign wrAux = regWrite && addrHit && (regAddr[2:0] == OFS_AUX_PORT_CHARGE);
  assign wrMode = regWrite && addrHit && (regAddr[2:0] == OFS_SENSOR_MODE);

  // ---------------------------------------------------------------
  // register 0x00: slow clock tuning
  // ---------------------------------------------------------------
  // bits 7:6 belong to the access port: stored and read back, but not decoded
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lowfreqClockTune <= RST_LOWFREQ_CLOCK_TUNE;
    end else if (wrTune) begin
      lowfreqClockTune <= regWrData; // R21
    end
  end

  // ---------------------------------------------------------------
  // register 0x01: fast oscillator control
  // ---------------------------------------------------------------
  // bits 4:3 are stored as written; nothing here acts on them
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      oscillatorControl <= RST_OSCILLATOR_CONTROL;
    end else if (wrOsc) begin
      oscillatorControl <= regWrData; // R21
    end
  end

  // ---------------------------------------------------------------
  // register 0x02: discharge resistor selection
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dischargeResistorSelect <= RST_DISCHARGE_RES_SEL;
    end else if (wrRes) begin
      dischargeResistorSelect <= regWrData; // R21
    end
  end

  // ---------------------------------------------------------------
  // register 0x03: aux port and charge control
  // ---------------------------------------------------------------
  // bits 4:3 keep their reset pattern unless software overwrites them
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      auxPortChargeControl <= RST_AUX_PORT_CHARGE;
    end else if (wrAux) begin
      auxPortChargeControl <= regWrData; // R21
    end
  end

  // ---------------------------------------------------------------
  // register 0x04: sensor mode control
  // ---------------------------------------------------------------
  // off-chip compensation is stored as written even with grounded sensors
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sensorModeControl <= RST_SENSOR_MODE;
    end else if (wrMode) begin
      sensorModeControl <= regWrData; // R21
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // unmapped indices and idle cycles read as zero, so the bus can be or-ed
  always_comb begin
    next_regRdData = 8'h00;
    if (regRead && addrHit) begin
      unique case (regAddr[2:0])
        OFS_LOWFREQ_CLOCK_TUNE: next_regRdData = lowfreqClockTune;
        OFS_OSCILLATOR_CONTROL: next_regRdData = oscillatorControl;
        OFS_DISCHARGE_RES_SEL: next_regRdData = dischargeResistorSelect;
        OFS_AUX_PORT_CHARGE: next_regRdData = auxPortChargeControl;
        OFS_SENSOR_MODE: next_regRdData = sensorModeControl;
        OFS_SEQ_STATUS: next_regRdData = seqStatus;
        default: next_regRdData = 8'h00;
      endcase
    end
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= next_regRdData;
    end
  end

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  always_comb begin
    cfg.slowClkFineTrim = lowfreqClockTune[FINE_TRIM_LSB +: 4]; // R1
    cfg.slowClkCoarseRange = lowfreqClockTune[COARSE_LSB +: 2]; // R2
    cfg.fastOscDisable = oscillatorControl[OSC_DISABLE_BIT]; // R3
    cfg.fastOscQuarter = oscillatorControl[OSC_QUARTER_BIT]; // R4
    cfg.fastOscRunMode = oscillatorControl[OSC_RUN_LSB +: 3]; // R5
    cfg.dischgResSelLowPorts = dischargeResistorSelect[DSEL_LOW_LSB +: 2]; // R7
    cfg.dischgResSelHighPorts = dischargeResistorSelect[DSEL_HIGH_LSB +: 2]; // R8
    cfg.internalDischgEnable = dischargeResistorSelect[INT_DSCHG_EN_BIT]; // R9
    cfg.externalDischgEnable = dischargeResistorSelect[EXT_DSCHG_EN_BIT]; // R10
    cfg.auxPulldownOff = auxPortChargeControl[AUX_PD_OFF_BIT]; // R11
    cfg.auxDuringIntref = auxPortChargeControl[AUX_INTREF_BIT]; // R12
    cfg.dischgResPermanent = auxPortChargeControl[DSCHG_PERM_BIT]; // R13
    cfg.auxPortPermanent = auxPortChargeControl[AUX_PERM_BIT]; // R14
    cfg.chargeResSelect = auxPortChargeControl[CHG_RES_BIT]; // R15
    cfg.refInternal = sensorModeControl[REF_INT_BIT]; // R16
    cfg.offchipParasiticComp = sensorModeControl[COMP_EXT_BIT];
    cfg.onchipParasiticComp = sensorModeControl[COMP_INT_BIT]; // R18
    cfg.differential = sensorModeControl[DIFF_BIT]; // R19
    cfg.floating = sensorModeControl[FLOAT_BIT]; // R20
  end

  // ---------------------------------------------------------------
  // aux pin and discharge resistor switching
  // ---------------------------------------------------------------
  // permanent mode wins; external switching follows the discharge phase only
  always_comb begin
    next_auxPinSwitch = cfg.auxPortPermanent // R14
      || (cfg.externalDischgEnable && dischargePhase // R10
          && (!cfg.auxDuringIntref || intRefConversion)) // R12
      || (cfg.auxDuringIntref && !cfg.externalDischgEnable && intRefConversion); // R12
    next_auxPulldownEnable = !cfg.auxPulldownOff; // R11
    next_intDischgConnect = cfg.internalDischgEnable
      && (cfg.dischgResPermanent || dischargePhase); // R13
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      auxPinSwitch <= 1'b0;
    end else begin
      auxPinSwitch <= next_auxPinSwitch; // R10
    end
  end

  // pull-down resets active so an unconfigured aux pin does not float
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      auxPulldownEnable <= 1'b1;
    end else begin
      auxPulldownEnable <= next_auxPulldownEnable; // R11
    end
  end

  // connection follows the discharge phase unless held permanently
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      intDischgConnect <= 1'b0;
    end else begin
      intDischgConnect <= next_intDischgConnect; // R13
    end
  end

  // ---------------------------------------------------------------
  // configuration consistency
  // ---------------------------------------------------------------

  // off-chip compensation without floating sensors is flagged, not blocked
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      configErr <= 1'b0;
    end else begin
      configErr <= cfg.offchipParasiticComp && !cfg.floating; // R17
    end
  end

  // ---------------------------------------------------------------
  // fast oscillator latency sequencing
  // ---------------------------------------------------------------
  // slow clock tick comes from another oscillator domain
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      slowTickMeta <= 1'b0;
      slowTickSync <= 1'b0;
      slowTickLast <= 1'b0;
    end else begin
      slowTickMeta <= slowClkTick;
      slowTickSync <= slowTickMeta;
      slowTickLast <= slowTickSync;
    end
  end

  // last tick resets low, the idle tick level, so no false edge follows reset
  assign slowTickRise = slowTickSync && !slowTickLast;

  always_comb begin
    unique case (cfg.fastOscRunMode)
      RUN_LAT_1: settleTarget = LAT_PERIODS_1;
      RUN_LAT_2: settleTarget = LAT_PERIODS_2;
      RUN_LAT_31: settleTarget = LAT_PERIODS_31;
      default: settleTarget = 5'h00;
    endcase
  end

  // a change to a run code without latency, or a disable, during settling abandons the wait instead of starting
  assign settleAbort = cfg.fastOscDisable || (settleTarget == 5'h00);

  // unlisted run codes behave as off
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      oscState <= ST_IDLE;
      settleCount <= 5'h00;
      measStart <= 1'b0;
    end else begin
      measStart <= 1'b0;
      unique case (oscState)
        ST_IDLE: begin
          settleCount <= 5'h00;
          if (measRequest && !cfg.fastOscDisable) begin
            if (settleTarget != 5'h00) begin
              oscState <= ST_SETTLE; // R6
            end else if (cfg.fastOscRunMode == RUN_PERMANENT) begin
              measStart <= 1'b1;
              oscState <= ST_MEASURE;
            end
          end
        end
        ST_SETTLE: begin
          if (settleAbort) begin
            oscState <= ST_IDLE;
          end else if (slowTickRise) begin
            if (settleCount + 5'h01 >= settleTarget) begin
              measStart <= 1'b1; // R6
              oscState <= ST_MEASURE;
            end
            settleCount <= settleCount + 5'h01;
          end
        end
        ST_MEASURE: begin
          if (!measRequest) begin
            oscState <= ST_IDLE;
          end
        end
        default: oscState <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // oscillator enable
  // ---------------------------------------------------------------
  always_comb begin
    next_fastOscEnable = !cfg.fastOscDisable // R3
      && ((cfg.fastOscRunMode == RUN_PERMANENT) // R5
          || (oscState != ST_IDLE && settleTarget != 5'h00)); // R6
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fastOscEnable <= 1'b0;
    end else begin
      fastOscEnable <= next_fastOscEnable; // R3
    end
  end

  // ---------------------------------------------------------------
  // status register
  // ---------------------------------------------------------------
  // read-only: state, oscillator enable and the compensation conflict flag
  assign seqStatus = {4'h0, configErr, fastOscEnable, oscState};

endmodule // cdc_frontend_config_regs

// ### testbench/cdc_frontend_config_regs_sva.sv
// checker: port-level properties of the front-end config bank
`timescale 1ns/1ps
module cdc_cfg_sva
  import cdc_cfg_pkg::*;
#(
  parameter int ADDR_W = 3
) (
  // clock, reset, register port
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // sequencer side
  input wire logic measRequest,
  input wire logic dischargePhase,
  input wire cdc_cfg_t cfg,
  input wire logic fastOscEnable,
  input wire logic measStart,
  input wire logic auxPinSwitch,
  input wire logic auxPulldownEnable,
  input wire logic intDischgConnect
);
  // write data of the previous cycle, so field checks need no $past on slices
  logic [7:0] lastWd;
  always_ff @(posedge sys_clk) begin
    lastWd <= regWrData;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  rd_idle_a: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data not zero outside read slot");
  tune_wr_a: assert property (regWrite && regAddr == OFS_LOWFREQ_CLOCK_TUNE |=>
    {cfg.slowClkFineTrim, cfg.slowClkCoarseRange} == lastWd[5:0])
    else $error("slow clock fields wrong after write");
  osc_wr_a: assert property (regWrite && regAddr == OFS_OSCILLATOR_CONTROL |=>
    {cfg.fastOscDisable, cfg.fastOscQuarter, cfg.fastOscRunMode}
      == {lastWd[7], lastWd[5], lastWd[2:0]})
    else $error("oscillator fields wrong after write");
  res_wr_a: assert property (regWrite && regAddr == OFS_DISCHARGE_RES_SEL |=>
    {cfg.dischgResSelHighPorts, cfg.dischgResSelLowPorts, cfg.internalDischgEnable,
     cfg.externalDischgEnable} == {lastWd[7:3], lastWd[1]})
    else $error("discharge fields wrong after write");
  aux_wr_a: assert property (regWrite && regAddr == OFS_AUX_PORT_CHARGE |=>
    {cfg.auxPulldownOff, cfg.auxDuringIntref, cfg.dischgResPermanent, cfg.auxPortPermanent,
     cfg.chargeResSelect} == {lastWd[6:5], lastWd[2:0]})
    else $error("aux fields wrong after write");
  mode_wr_a: assert property (regWrite && regAddr == OFS_SENSOR_MODE |=>
    {cfg.refInternal, cfg.offchipParasiticComp, cfg.onchipParasiticComp, cfg.differential,
     cfg.floating} == {lastWd[7], lastWd[5:4], lastWd[1:0]})
    else $error("sensor mode fields wrong after write");
  start_pulse_a: assert property (measStart |=> !measStart)
    else $error("start pulse longer than one cycle");
  start_gate_a: assert property (cfg.fastOscRunMode == RUN_OFF || cfg.fastOscDisable |=> !measStart)
    else $error("start while oscillator off or disabled");
  perm_start_a: assert property ($rose(measRequest) && cfg.fastOscRunMode == RUN_PERMANENT
    && !cfg.fastOscDisable |=> measStart)
    else $error("permanent mode start not immediate");
  osc_on_a: assert property (cfg.fastOscRunMode == RUN_PERMANENT && !cfg.fastOscDisable
    |=> fastOscEnable)
    else $error("oscillator off in permanent mode");
  pd_off_a: assert property (cfg.auxPulldownOff |=> !auxPulldownEnable)
    else $error("pull-down active while disabled");
  ext_sw_a: assert property (cfg.externalDischgEnable && dischargePhase
    && !cfg.auxDuringIntref |=> auxPinSwitch)
    else $error("aux not switched in discharge");
  no_sw_a: assert property (!cfg.externalDischgEnable && !cfg.auxPortPermanent
    && !cfg.auxDuringIntref |=> !auxPinSwitch)
    else $error("aux switched with no mode set");
  perm_sw_a: assert property (cfg.auxPortPermanent |=> auxPinSwitch)
    else $error("aux not permanent");
  perm_con_a: assert property (cfg.dischgResPermanent && cfg.internalDischgEnable
    |=> intDischgConnect)
    else $error("discharge resistor not kept connected");
  cover property (measStart);
  cover property (auxPinSwitch);
  cover property (regRead ##1 regRdData != 8'h00);
endmodule // cdc_cfg_sva

bind cdc_frontend_config_regs cdc_cfg_sva #(.ADDR_W(ADDR_W)) chk_u (
  .sys_clk, .srst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .measRequest,
  .dischargePhase, .cfg, .fastOscEnable, .measStart, .auxPinSwitch, .auxPulldownEnable,
  .intDischgConnect
);

// ### testbench/testbench.sv
// testbench: self-checking scenarios for the front-end config bank
`timescale 1ns/1ps
module testbench;
  import cdc_cfg_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic slowClkTick = 1'b0;
  logic measRequest = 1'b0;
  logic dischargePhase = 1'b0;
  logic intRefConversion = 1'b0;
  logic [7:0] regRdData;
  cdc_cfg_t cfg;
  logic fastOscEnable, measStart, auxPinSwitch, auxPulldownEnable, intDischgConnect;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;

  cdc_frontend_config_regs dut_u (
    .sys_clk, .srst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .slowClkTick, .measRequest, .dischargePhase, .intRefConversion, .cfg,
    .fastOscEnable, .measStart, .auxPinSwitch, .auxPulldownEnable, .intDischgConnect
  );

  initial forever #5 sys_clk = ~sys_clk;

  // longest run is a few thousand cycles; the ceiling leaves ample margin
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 chk("read data", regRdData, exp);
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] rv [5];
    rv = '{RST_LOWFREQ_CLOCK_TUNE, RST_OSCILLATOR_CONTROL, RST_DISCHARGE_RES_SEL,
           RST_AUX_PORT_CHARGE, RST_SENSOR_MODE};
    for (int i = 0; i < 5; i++) rd(3'(i), rv[i]);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    @(posedge sys_clk);
    #1 chk("read idle", regRdData, 8'h00);
  endtask
  task automatic t_rw();
    logic [7:0] d;
    for (int v = 0; v < 256; v += 51) begin
      for (int i = 0; i < 5; i++) begin
        // never set off-chip compensation with grounded sensors
        d = (i == 4) ? 8'(v | ((v >> 5) & 1)) : 8'(v);
        wr(3'(i), d);
        rd(3'(i), d);
      end
      #1 chk("fine trim", 8'(cfg.slowClkFineTrim), 8'((v >> 2) & 15));
      chk("coarse", 8'(cfg.slowClkCoarseRange), 8'(v & 3));
    end
  endtask
  task automatic t_osc(input logic [7:0] r1, input int n);
    int ticks;
    int seen;
    ticks = 0;
    seen = -1;
    wr(OFS_OSCILLATOR_CONTROL, r1);
    @(posedge sys_clk);
    measRequest <= 1'b1;
    for (int c = 0; c < 800 && seen < 0; c++) begin
      @(posedge sys_clk);
      if (c % 20 == 10) begin
        slowClkTick <= 1'b1;
        ticks++;
      end
      if (c % 20 == 0) slowClkTick <= 1'b0;
      #1;
      if (measStart === 1'b1) seen = ticks;
    end
    chk("latency ticks", 8'(seen), 8'(n));
    chk("osc enable", 8'(fastOscEnable), 8'(n >= 0));
    rd(OFS_SEQ_STATUS, (n >= 0) ? 8'h07 : 8'h00);
    @(posedge sys_clk);
    measRequest <= 1'b0;
    slowClkTick <= 1'b0;
    repeat (25) @(posedge sys_clk);
  endtask
  task automatic t_aux(input logic [7:0] r2, input logic [7:0] r3, input logic dis,
                       input logic iref, input logic [2:0] exp);
    wr(OFS_DISCHARGE_RES_SEL, r2);
    wr(OFS_AUX_PORT_CHARGE, r3);
    @(posedge sys_clk);
    dischargePhase <= dis;
    intRefConversion <= iref;
    repeat (3) @(posedge sys_clk);
    #1 chk("switch pulldown connect",
           {5'h00, auxPinSwitch, auxPulldownEnable, intDischgConnect}, {5'h00, exp});
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_rw();
    t_osc(8'h01, 0);
    t_osc(8'h06, 1);
    t_osc(8'h03, 2);
    t_osc(8'h02, 31);
    t_osc(8'h21, 0);
    t_osc(8'h00, -1);
    t_osc(8'h04, -1);
    t_osc(8'h81, -1);
    t_aux(8'hA8, 8'h00, 1'b0, 1'b0, 3'b010);
    t_aux(8'hA8, 8'h04, 1'b0, 1'b0, 3'b011);
    t_aux(8'hA8, 8'h00, 1'b1, 1'b0, 3'b011);
    t_aux(8'hA0, 8'h00, 1'b1, 1'b0, 3'b010);
    t_aux(8'hAA, 8'h40, 1'b1, 1'b0, 3'b101);
    t_aux(8'hAA, 8'h40, 1'b0, 1'b0, 3'b000);
    t_aux(8'hA8, 8'h42, 1'b0, 1'b0, 3'b100);
    t_aux(8'hA8, 8'h60, 1'b0, 1'b1, 3'b100);
    t_aux(8'hA8, 8'h60, 1'b0, 1'b0, 3'b000);
    print_verdict();
  end
endmodule // testbench
